// file: rtl/module_mgmt_status_timing.sv
// management control, status and 2-wire serial slave of a four-lane module
// assumes all pins asynchronous to clock; the host pulls up sda and interrupt
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_status_timing #(
  parameter int LANES = 4,
  parameter int unsigned INIT_CYCLES = mgmt_pkg::INIT_CYC,
  parameter logic [247:0] EXT_ID = 248'h0, // bytes 192..222, byte 192 lowest
  parameter logic [255:0] VENDOR_AREA = 256'h0 // bytes 224..255, arbitrary
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_select_in,
  input wire logic interrupt_n_in,
  output logic interrupt_n_out,
  output logic interrupt_n_oe,
  output logic low_power_out,
  input wire logic [LANES-1:0] rx_los_in,
  input wire logic [LANES-1:0] tx_fault_in,
  input wire logic [LANES-1:0] other_cond_in
);
  localparam int NSYNC = 5 + 3 * LANES;
  localparam logic [7:0] RST_CYC = 8'(mgmt_pkg::RESET_MIN_CYC);

  if (LANES < 1 || LANES > 8) begin : g_lanes_chk
    $error("LANES must be 1 to 8");
  end
  if (INIT_CYCLES < 1 || mgmt_pkg::RESET_MIN_CYC > 255) begin : g_cnt_chk
    $error("timing counts out of range");
  end

  function automatic logic [7:0] sum_bytes(input logic [247:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 31; i++) begin
      s = 8'(s + d[i*8 +: 8]);
    end
    return s;
  endfunction
  localparam logic [7:0] EXT_CSUM = sum_bytes(EXT_ID);

  // two-stage synchronisers for every input pin except interrupt_n_in
  logic [NSYNC-1:0] async_vec, s1_r, s2_r;
  logic scl_d_r, sda_d_r;
  assign async_vec = {other_cond_in, tx_fault_in, rx_los_in, low_power_select_in,
                      module_select_n_in, module_reset_n_in, sda_in, scl_in};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        s1_r[i] <= (i == 1 || i == 2 || i == 3 || i == 0);
        s2_r[i] <= (i == 1 || i == 2 || i == 3 || i == 0);
      end else begin
        s1_r[i] <= async_vec[i];
        s2_r[i] <= s1_r[i];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= s2_r[0];
      sda_d_r <= s2_r[1];
    end
  end

  logic scl_s, sda_s, rst_n_s, sel_n_s, lp_s;
  logic [LANES-1:0] los_s, fault_s, other_s;
  assign scl_s = s2_r[0];
  assign sda_s = s2_r[1];
  assign rst_n_s = s2_r[2];
  assign sel_n_s = s2_r[3];
  assign lp_s = s2_r[4];
  assign los_s = s2_r[5 +: LANES];
  assign fault_s = s2_r[5 + LANES +: LANES];
  assign other_s = s2_r[5 + 2 * LANES +: LANES];

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // status group
  logic [7:0] rst_cnt_r, rst_cnt_nxt;
  logic mod_rst_r, mod_rst_nxt, dnr_r, dnr_nxt, init_flag_r, init_flag_nxt;
  logic [31:0] init_cnt_r, init_cnt_nxt;
  logic [LANES-1:0] los_flag_r, los_flag_nxt, fault_flag_r, fault_flag_nxt;
  logic [LANES-1:0] other_flag_r, other_flag_nxt;
  logic irq_r, irq_nxt, lp_r, lp_nxt;
  // bus group
  mgmt_pkg::bus_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt, clr_pend_r, clr_pend_nxt, clr_r, clr_nxt, rd_clr;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, page_r, page_nxt, ctrl_r, ctrl_nxt;
  logic [7:0] mask_los_r, mask_los_nxt, mask_fault_r, mask_fault_nxt;
  logic [7:0] mask_other_r, mask_other_nxt, rd_data;
  logic rd_r, rd_nxt, first_r, first_nxt, oe_r, oe_nxt, ack_r, ack_nxt, nv_we;
  logic [7:0] user_nv [0:127];

  always_comb begin
    rst_cnt_nxt = 8'h00;
    mod_rst_nxt = 1'b0;
    if (!rst_n_s) begin
      rst_cnt_nxt = (rst_cnt_r == RST_CYC) ? rst_cnt_r : 8'(rst_cnt_r + 8'h01);
      mod_rst_nxt = mod_rst_r | (rst_cnt_r == RST_CYC);
    end
    init_cnt_nxt = init_cnt_r;
    dnr_nxt = dnr_r;
    init_flag_nxt = init_flag_r & ~clr_r[0];
    los_flag_nxt = (los_flag_r & ~{LANES{clr_r[1]}}) | los_s;
    fault_flag_nxt = (fault_flag_r & ~{LANES{clr_r[2]}}) | fault_s;
    other_flag_nxt = (other_flag_r & ~{LANES{clr_r[3]}}) | other_s;
    if (mod_rst_r) begin
      init_cnt_nxt = 32'h0000_0000;
      dnr_nxt = 1'b1;
      init_flag_nxt = 1'b0;
      los_flag_nxt = '0;
      fault_flag_nxt = '0;
      other_flag_nxt = '0;
    end else if (dnr_r) begin
      if (init_cnt_r == 32'(INIT_CYCLES - 1)) begin
        dnr_nxt = 1'b0;
        init_flag_nxt = 1'b1;
      end else begin
        init_cnt_nxt = 32'(init_cnt_r + 32'h0000_0001);
      end
    end
    // level of unmasked flags; mask applies next cycle after its write
    irq_nxt = init_flag_r | |(los_flag_r & ~mask_los_r[LANES-1:0])
            | |(fault_flag_r & ~mask_fault_r[LANES-1:0])
            | |(other_flag_r & ~mask_other_r[LANES-1:0]);
    lp_nxt = lp_s | ctrl_r[mgmt_pkg::PDOWN_BIT];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_cnt_r <= 8'h00;
      mod_rst_r <= 1'b0;
      init_cnt_r <= 32'h0000_0000;
      dnr_r <= 1'b1;
      init_flag_r <= 1'b0;
      los_flag_r <= '0;
      fault_flag_r <= '0;
      other_flag_r <= '0;
      irq_r <= 1'b0;
      lp_r <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      mod_rst_r <= mod_rst_nxt;
      init_cnt_r <= init_cnt_nxt;
      dnr_r <= dnr_nxt;
      init_flag_r <= init_flag_nxt;
      los_flag_r <= los_flag_nxt;
      fault_flag_r <= fault_flag_nxt;
      other_flag_r <= other_flag_nxt;
      irq_r <= irq_nxt;
      lp_r <= lp_nxt;
    end
  end

  // read data for the current pointer, and which flags that read clears
  always_comb begin
    rd_data = 8'h00;
    rd_clr = 4'h0;
    if (!ptr_r[7]) begin
      unique case (ptr_r)
        mgmt_pkg::STATUS_ADDR: begin
          rd_data[mgmt_pkg::DNR_BIT] = dnr_r;
          rd_clr[0] = 1'b1;
        end
        mgmt_pkg::FLAG_LOS_ADDR: begin
          rd_data[LANES-1:0] = los_flag_r;
          rd_clr[1] = 1'b1;
        end
        mgmt_pkg::FLAG_FAULT_ADDR: begin
          rd_data[LANES-1:0] = fault_flag_r;
          rd_clr[2] = 1'b1;
        end
        mgmt_pkg::FLAG_OTHER_ADDR: begin
          rd_data[LANES-1:0] = other_flag_r;
          rd_clr[3] = 1'b1;
        end
        mgmt_pkg::CTRL_ADDR: rd_data = ctrl_r;
        mgmt_pkg::MASK_LOS_ADDR: rd_data = mask_los_r;
        mgmt_pkg::MASK_FAULT_ADDR: rd_data = mask_fault_r;
        mgmt_pkg::MASK_OTHER_ADDR: rd_data = mask_other_r;
        mgmt_pkg::PAGE_SEL_ADDR: rd_data = page_r;
        default: rd_data = 8'h00;
      endcase
    end else if (page_r == mgmt_pkg::PAGE_ID) begin
      if (ptr_r >= mgmt_pkg::EXT_ID_FIRST && ptr_r <= mgmt_pkg::EXT_ID_LAST) begin
        rd_data = EXT_ID[(int'(ptr_r) - int'(mgmt_pkg::EXT_ID_FIRST)) * 8 +: 8];
      end else if (ptr_r == mgmt_pkg::EXT_ID_CSUM_ADDR) begin
        rd_data = EXT_CSUM;
      end else if (ptr_r >= mgmt_pkg::VENDOR_FIRST) begin
        rd_data = VENDOR_AREA[(int'(ptr_r) - int'(mgmt_pkg::VENDOR_FIRST)) * 8 +: 8];
      end
    end else if (page_r == mgmt_pkg::PAGE_USER) begin
      rd_data = user_nv[ptr_r[6:0]];
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rd_nxt = rd_r;
    first_nxt = first_r;
    oe_nxt = oe_r;
    ack_nxt = ack_r;
    clr_pend_nxt = clr_pend_r;
    clr_nxt = 4'h0;
    page_nxt = page_r;
    ctrl_nxt = ctrl_r;
    mask_los_nxt = mask_los_r;
    mask_fault_nxt = mask_fault_r;
    mask_other_nxt = mask_other_r;
    nv_we = 1'b0;
    if (sel_n_s) begin
      st_nxt = mgmt_pkg::BUS_IDLE;
      oe_nxt = 1'b0;
    end else if (bus_start) begin
      st_nxt = mgmt_pkg::BUS_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      first_nxt = 1'b1;
    end else if (bus_stop) begin
      st_nxt = mgmt_pkg::BUS_IDLE;
      oe_nxt = 1'b0;
      clr_nxt = clr_pend_r;
      clr_pend_nxt = 4'h0;
    end else begin
      unique case (st_r)
        mgmt_pkg::BUS_IDLE: begin
        end
        mgmt_pkg::BUS_ADDR, mgmt_pkg::BUS_WBYTE: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = 4'(cnt_r + 4'h1);
          end else if (scl_fall && cnt_r == 4'h8) begin
            oe_nxt = 1'b1;
            if (st_r == mgmt_pkg::BUS_ADDR) begin
              rd_nxt = sh_r[0];
              st_nxt = mgmt_pkg::BUS_AACK;
              if (sh_r[7:1] != mgmt_pkg::DEV_ADDR) begin
                oe_nxt = 1'b0;
                st_nxt = mgmt_pkg::BUS_IDLE;
              end
            end else begin
              st_nxt = mgmt_pkg::BUS_WACK;
              first_nxt = 1'b0;
              if (first_r) begin
                ptr_nxt = sh_r;
              end else begin
                ptr_nxt = 8'(ptr_r + 8'h01);
                unique case (ptr_r)
                  mgmt_pkg::CTRL_ADDR: ctrl_nxt = sh_r;
                  mgmt_pkg::MASK_LOS_ADDR: mask_los_nxt = sh_r;
                  mgmt_pkg::MASK_FAULT_ADDR: mask_fault_nxt = sh_r;
                  mgmt_pkg::MASK_OTHER_ADDR: mask_other_nxt = sh_r;
                  mgmt_pkg::PAGE_SEL_ADDR: page_nxt = sh_r;
                  default: nv_we = ptr_r[7] && (page_r == mgmt_pkg::PAGE_USER);
                endcase
              end
            end
          end
        end
        mgmt_pkg::BUS_WACK, mgmt_pkg::BUS_AACK, mgmt_pkg::BUS_RACK: begin
          if (scl_rise) begin
            ack_nxt = ~sda_s;
          end else if (scl_fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt = mgmt_pkg::BUS_WBYTE;
            if ((st_r == mgmt_pkg::BUS_AACK && rd_r) || (st_r == mgmt_pkg::BUS_RACK && ack_r)) begin
              oe_nxt = ~rd_data[7];
              sh_nxt = {rd_data[6:0], 1'b0};
              cnt_nxt = 4'h1;
              ptr_nxt = 8'(ptr_r + 8'h01);
              clr_pend_nxt = clr_pend_r | rd_clr;
              st_nxt = mgmt_pkg::BUS_RBYTE;
            end else if (st_r == mgmt_pkg::BUS_RACK) begin
              st_nxt = mgmt_pkg::BUS_IDLE;
            end
          end
        end
        mgmt_pkg::BUS_RBYTE: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt = 1'b0;
              st_nxt = mgmt_pkg::BUS_RACK;
            end else begin
              oe_nxt = ~sh_r[7];
              sh_nxt = {sh_r[6:0], 1'b0};
              cnt_nxt = 4'(cnt_r + 4'h1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= mgmt_pkg::BUS_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rd_r <= 1'b0;
      first_r <= 1'b1;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
      clr_pend_r <= 4'h0;
      clr_r <= 4'h0;
      page_r <= mgmt_pkg::PAGE_RST;
      ctrl_r <= mgmt_pkg::CTRL_RST;
      mask_los_r <= mgmt_pkg::MASK_RST;
      mask_fault_r <= mgmt_pkg::MASK_RST;
      mask_other_r <= mgmt_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rd_r <= rd_nxt;
      first_r <= first_nxt;
      oe_r <= oe_nxt;
      ack_r <= ack_nxt;
      clr_pend_r <= clr_pend_nxt;
      clr_r <= clr_nxt;
      page_r <= page_nxt;
      ctrl_r <= ctrl_nxt;
      mask_los_r <= mask_los_nxt;
      mask_fault_r <= mask_fault_nxt;
      mask_other_r <= mask_other_nxt;
    end
  end

  // user area has no reset: it stands for nonvolatile storage
  always_ff @(posedge clock) begin
    if (nv_we) begin
      user_nv[ptr_r[6:0]] <= sh_r;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign interrupt_n_out = 1'b0;
  assign interrupt_n_oe = irq_r;
  assign low_power_out = lp_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  los_sets_irq_a: assert property (|(los_s & ~mask_los_r[LANES-1:0]) && !mod_rst_r |-> ##[1:3] interrupt_n_oe)
    else $error("signal loss did not raise interrupt");
  fault_flag_a: assert property (|fault_s && !mod_rst_r |=> |fault_flag_r)
    else $error("transmit fault flag not set");
  irq_release_a: assert property (!init_flag_r && (los_flag_r & ~mask_los_r[LANES-1:0]) == '0
    && (fault_flag_r & ~mask_fault_r[LANES-1:0]) == '0
    && (other_flag_r & ~mask_other_r[LANES-1:0]) == '0 |=> !interrupt_n_oe)
    else $error("interrupt held with no unmasked flag");
  low_power_a: assert property (lp_s |=> low_power_out)
    else $error("low power pin not honoured");
  pdown_bit_a: assert property ($rose(ctrl_r[mgmt_pkg::PDOWN_BIT]) |=> low_power_out)
    else $error("power-down bit not honoured");
  reset_filter_a: assert property ($rose(mod_rst_r) |-> $past(rst_cnt_r) == RST_CYC)
    else $error("reset accepted before minimum low time");
  init_done_a: assert property ($fell(dnr_r) |-> init_flag_r ##1 interrupt_n_oe)
    else $error("init end did not raise interrupt");
  deselect_a: assert property (sel_n_s |=> st_r == mgmt_pkg::BUS_IDLE && !sda_oe)
    else $error("bus still active while deselected");
  read_clear_a: assert property (bus_stop && !sel_n_s && clr_pend_r[1] |=> clr_r[1])
    else $error("read-clear not applied at stop");
endmodule
`default_nettype wire

// file: rtl/mgmt_pkg.sv
// constants for the module management status and timing block
// assumes a 40 MHz system clock and a 2-wire serial bus sampled on it
`default_nettype none
package mgmt_pkg;
  // clock
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  // initialisation time after power-on or reset release
  localparam int INIT_TIME_MS = 2000;
  localparam int INIT_CYC = INIT_TIME_MS * (CLK_HZ / 1000);
  // least low time on the reset pin, rounded up to whole cycles
  localparam int RESET_MIN_NS = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus device address, 8-bit form 0xA0
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // lower page offsets
  localparam logic [7:0] STATUS_ADDR = 8'h02;
  localparam logic [7:0] FLAG_LOS_ADDR = 8'h03;
  localparam logic [7:0] FLAG_FAULT_ADDR = 8'h04;
  localparam logic [7:0] FLAG_OTHER_ADDR = 8'h05;
  localparam logic [7:0] CTRL_ADDR = 8'h5d;
  localparam logic [7:0] MASK_LOS_ADDR = 8'h64;
  localparam logic [7:0] MASK_FAULT_ADDR = 8'h65;
  localparam logic [7:0] MASK_OTHER_ADDR = 8'h66;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'h7f;
  // upper identification page offsets, then page select values
  localparam logic [7:0] EXT_ID_FIRST = 8'hc0;
  localparam logic [7:0] EXT_ID_LAST = 8'hde;
  localparam logic [7:0] EXT_ID_CSUM_ADDR = 8'hdf;
  localparam logic [7:0] VENDOR_FIRST = 8'he0;
  localparam logic [7:0] PAGE_ID = 8'h00;
  localparam logic [7:0] PAGE_USER = 8'h02;
  // field positions
  localparam int DNR_BIT = 0;
  localparam int PDOWN_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_AACK, BUS_WBYTE, BUS_WACK, BUS_RBYTE, BUS_RACK
  } bus_state_t;
endpackage
`default_nettype wire

// file: tb/bus_host_model.sv
// host side master of the 2-wire serial bus
// assumes the bench resolves sda from both open-drain pull-downs
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // 8-clock slot, 200 ns; sda moves only while scl is low
  task automatic bit_slot(input logic b, output logic got);
    tick(2);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    got = sda;
    scl = 1'b0;
  endtask
  // waits out a device ack before scl rises again
  task automatic start_cond();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack_n);
    logic d;
    for (int i = 7; i >= 0; i--) bit_slot(v[i], d);
    bit_slot(1'b1, ack_n);
  endtask
  // one byte read; last ends it by a nack, else the master acks for more
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic d;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
    bit_slot(last, d);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic ack_n);
    logic a0, a1, a2;
    start_cond();
    send_byte({mgmt_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(p, a1);
    send_byte(v, a2);
    stop_cond();
    ack_n = a0 | a1 | a2;
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic ack_n);
    logic a0, a1, a2;
    start_cond();
    send_byte({mgmt_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(p, a1);
    start_cond();
    send_byte({mgmt_pkg::DEV_ADDR, 1'b1}, a2);
    get_byte(1'b1, v);
    stop_cond();
    ack_n = a0 | a1 | a2;
  endtask
  // two bytes in one read: master ack after the first, nack after the second
  task automatic read_pair(input logic [7:0] p, output logic [7:0] v0, output logic [7:0] v1,
                           output logic ack_n);
    logic a0, a1, a2;
    start_cond();
    send_byte({mgmt_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(p, a1);
    start_cond();
    send_byte({mgmt_pkg::DEV_ADDR, 1'b1}, a2);
    get_byte(1'b0, v0);
    get_byte(1'b1, v1);
    stop_cond();
    ack_n = a0 | a1 | a2;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the management status and timing block
// assumes the host model above as bus master; pull-ups modelled here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int INIT_SIM = 2000;
  localparam int MAX_CYC = 30000;
  localparam logic [247:0] EXT_SIM = {31{8'h35}};
  localparam logic [255:0] VEND_SIM = {{31{8'h11}}, 8'ha5};
  logic clock, sys_rst, scl, sda_low, reset_n, select_n, lp_sel;
  logic [3:0] rx_los, tx_fault, other_cond;
  logic sda_oe, int_oe, low_power_out, sda_dout, int_dout;
  int err_count, n_compared, cycles;
  // open-drain lines with host pull-ups; a driven pin shows the device's level
  wire sda_line = ~sda_low & (sda_oe ? sda_dout : 1'b1);
  wire int_line_n = int_oe ? int_dout : 1'b1;
  module_mgmt_status_timing #(
    .LANES(4), .INIT_CYCLES(INIT_SIM), .EXT_ID(EXT_SIM), .VENDOR_AREA(VEND_SIM)
  ) module_mgmt_status_timing_inst (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_dout), .sda_oe(sda_oe), .module_reset_n_in(reset_n),
    .module_select_n_in(select_n), .low_power_select_in(lp_sel),
    .interrupt_n_in(int_line_n), .interrupt_n_out(int_dout), .interrupt_n_oe(int_oe),
    .low_power_out(low_power_out), .rx_los_in(rx_los), .tx_fault_in(tx_fault),
    .other_cond_in(other_cond)
  );
  bus_host_model bus_host_model_inst (
    .clock(clock), .sda(sda_line), .scl(scl), .sda_low(sda_low)
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles >= MAX_CYC) begin
        err_count++;
        $display("wrong value run length expected %0d seen %0d", MAX_CYC, cycles);
        wrap_up();
      end
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask
  // which 0 watches the interrupt pin, 1 the power level
  task automatic wait_pin(input int which, input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    while ((which == 0 ? int_line_n : low_power_out) !== lvl && n < lim) begin
      step(1);
      n++;
    end
    check1(what, lvl, which == 0 ? int_line_n : low_power_out);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic a;
    bus_host_model_inst.write_reg(p, v, a);
    check1("write ack", 1'b0, a);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic a;
    bus_host_model_inst.read_reg(p, v, a);
    check1("read ack", 1'b0, a);
  endtask
  initial begin
    logic [7:0] v, v2, csum;
    logic a;
    err_count = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    reset_n = 1'b1;
    select_n = 1'b0;
    lp_sel = 1'b0;
    rx_los = 4'h0;
    tx_fault = 4'h0;
    other_cond = 4'h0;
    step(3);
    sys_rst = 1'b0;
    step(3);
    check1("interrupt idle", 1'b1, int_line_n);
    rd(mgmt_pkg::STATUS_ADDR, v);
    check1("not ready early", 1'b1, v[mgmt_pkg::DNR_BIT]);
    wait_pin(0, 1'b0, INIT_SIM, "init interrupt");
    rd(mgmt_pkg::STATUS_ADDR, v);
    check1("ready", 1'b0, v[mgmt_pkg::DNR_BIT]);
    wait_pin(0, 1'b1, 8, "init event cleared");
    // loss, fault and other flags in turn, lane 1
    for (int k = 0; k < 3; k++) begin
      rx_los = k == 0 ? 4'h2 : 4'h0;
      tx_fault = k == 1 ? 4'h2 : 4'h0;
      other_cond = k == 2 ? 4'h2 : 4'h0;
      wait_pin(0, 1'b0, 8, "flag interrupt");
      rx_los = 4'h0;
      tx_fault = 4'h0;
      other_cond = 4'h0;
      rd(mgmt_pkg::FLAG_LOS_ADDR + 8'(k), v);
      check8("flag byte", 8'h02, v);
      wait_pin(0, 1'b1, 8, "flag release");
      rd(mgmt_pkg::FLAG_LOS_ADDR + 8'(k), v);
      check8("flag cleared", 8'h00, v);
    end
    wr(mgmt_pkg::MASK_LOS_ADDR, 8'h01);
    rx_los = 4'h1;
    step(20);
    check1("masked", 1'b1, int_line_n);
    wr(mgmt_pkg::MASK_LOS_ADDR, 8'h00);
    wait_pin(0, 1'b0, 8, "unmasked");
    tx_fault = 4'h8;
    rx_los = 4'h0;
    step(8);
    rd(mgmt_pkg::FLAG_LOS_ADDR, v);
    check8("loss flag", 8'h01, v);
    step(8);
    check1("held by fault", 1'b0, int_line_n);
    tx_fault = 4'h0;
    rd(mgmt_pkg::FLAG_FAULT_ADDR, v);
    check8("fault flag", 8'h08, v);
    wait_pin(0, 1'b1, 8, "all cleared");
    // fault and other masks: flags still latch, interrupt stays off
    wr(mgmt_pkg::MASK_FAULT_ADDR, 8'h0f);
    wr(mgmt_pkg::MASK_OTHER_ADDR, 8'h0f);
    tx_fault = 4'h1;
    other_cond = 4'h4;
    step(20);
    check1("fault other masked", 1'b1, int_line_n);
    tx_fault = 4'h0;
    other_cond = 4'h0;
    rd(mgmt_pkg::FLAG_OTHER_ADDR, v);
    check8("masked other flag", 8'h04, v);
    rd(mgmt_pkg::MASK_OTHER_ADDR, v);
    check8("other mask", 8'h0f, v);
    wr(mgmt_pkg::MASK_OTHER_ADDR, 8'h00);
    wr(mgmt_pkg::MASK_FAULT_ADDR, 8'h00);
    // latched fault flag now reaches the pin
    wait_pin(0, 1'b0, 8, "fault unmasked");
    rd(mgmt_pkg::FLAG_FAULT_ADDR, v);
    check8("masked fault flag", 8'h01, v);
    wait_pin(0, 1'b1, 8, "fault cleared");
    lp_sel = 1'b1;
    wait_pin(1, 1'b1, 8, "low power pin");
    lp_sel = 1'b0;
    wait_pin(1, 1'b0, 8, "low power pin off");
    wr(mgmt_pkg::CTRL_ADDR, 8'h02);
    wait_pin(1, 1'b1, 8, "power down bit");
    rd(mgmt_pkg::CTRL_ADDR, v);
    check8("control", 8'h02, v);
    wr(mgmt_pkg::CTRL_ADDR, 8'h00);
    wait_pin(1, 1'b0, 8, "power down off");
    select_n = 1'b1;
    step(8);
    bus_host_model_inst.read_reg(mgmt_pkg::STATUS_ADDR, v, a);
    check1("deselected ack", 1'b1, a);
    select_n = 1'b0;
    step(8);
    rd(mgmt_pkg::STATUS_ADDR, v);
    wr(mgmt_pkg::PAGE_SEL_ADDR, mgmt_pkg::PAGE_ID);
    csum = 8'h00;
    for (int b = 0; b < 31; b++) csum = csum + EXT_SIM[8*b +: 8];
    rd(mgmt_pkg::EXT_ID_CSUM_ADDR, v);
    check8("id checksum", csum, v);
    rd(mgmt_pkg::VENDOR_FIRST, v);
    check8("vendor first", 8'ha5, v);
    rd(8'hff, v);
    check8("vendor last", 8'h11, v);
    // master ack carries the read on to the next byte
    bus_host_model_inst.read_pair(mgmt_pkg::VENDOR_FIRST, v, v2, a);
    check1("pair ack", 1'b0, a);
    check8("pair first", 8'ha5, v);
    check8("pair second", 8'h11, v2);
    wr(mgmt_pkg::PAGE_SEL_ADDR, mgmt_pkg::PAGE_USER);
    wr(8'h80, 8'h3c);
    rd(8'h80, v);
    check8("user page", 8'h3c, v);
    wr(mgmt_pkg::PAGE_SEL_ADDR, mgmt_pkg::PAGE_ID);
    // a glitch shorter than the minimum pulse is ignored
    reset_n = 1'b0;
    step(40);
    reset_n = 1'b1;
    rd(mgmt_pkg::STATUS_ADDR, v);
    check1("short pulse", 1'b0, v[mgmt_pkg::DNR_BIT]);
    reset_n = 1'b0;
    step(100);
    rd(mgmt_pkg::STATUS_ADDR, v);
    check1("in reset", 1'b1, v[mgmt_pkg::DNR_BIT]);
    reset_n = 1'b1;
    wait_pin(0, 1'b0, INIT_SIM + 8, "reset init");
    rd(mgmt_pkg::STATUS_ADDR, v);
    check1("ready again", 1'b0, v[mgmt_pkg::DNR_BIT]);
    wait_pin(0, 1'b1, 8, "reset init cleared");
    wrap_up();
  end
endmodule
`default_nettype wire
